// ### flrs_params.svh
`ifndef FLRS_PARAMS_SVH
`define FLRS_PARAMS_SVH
// Geometry
`define FLRS_NCH 8
`define FLRS_NBUS 4
`define FLRS_NSRC 16
// Register byte offsets
`define FLRS_OFF_STATUS 12'h000
`define FLRS_OFF_MASK 12'h004
`define FLRS_OFF_CTRL 12'h008
`define FLRS_OFF_FAULT 12'h00C
`define FLRS_OFF_RETRYMAX 12'h010
`define FLRS_OFF_RETRYMS 12'h014
`define FLRS_OFF_FUSEINIT 12'h018
`define FLRS_OFF_CANCFG 12'h01C
`define FLRS_OFF_ACTIVE 12'h020
// Reset values
`define FLRS_RST_RETRYMAX 4'h3
`define FLRS_RST_RETRYMS 16'h000A
`define FLRS_RST_FUSEINIT 16'h00C8
// Timing
`define FLRS_CLK_MHZ 125
`define FLRS_MS_NS 1000000
`define FLRS_CLK_NS 8
`define FLRS_MS_CYC (`FLRS_MS_NS / `FLRS_CLK_NS)
`define FLRS_DEB_NS 1000
`define FLRS_DEB_CYC ((`FLRS_DEB_NS + `FLRS_CLK_NS - 1) / `FLRS_CLK_NS)
`define FLRS_CANRST_NS 1000
`define FLRS_CANRST_CYC ((`FLRS_CANRST_NS + `FLRS_CLK_NS - 1) / `FLRS_CLK_NS)
`endif

// ### flrs_pkg.sv
package flrs_pkg;
	// Per-channel trip inputs
	typedef struct packed {
		logic [7:0] highCurrentTrip;
		logic [7:0] continuousCurrentTrip;
		logic [7:0] softwareFuseTrip;
	} flrs_trip_t;
	// Reset source selection
	typedef struct packed {
		logic [3:0] sel;
		logic invert;
		logic useLamp;
	} flrs_rsrc_t;
	typedef enum logic [1:0] {CH_OFF, CH_ON, CH_WAIT, CH_ERROR} flrs_ch_t;
endpackage : flrs_pkg

// ### flrs_fault_supervisor.sv
// Decided for this implementation: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "flrs_params.svh"
module flrs_fault_supervisor
	import flrs_pkg::*;
#(
	parameter int MS_CYCLES = `FLRS_MS_CYC,
	parameter int DEB_CYCLES = `FLRS_DEB_CYC
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire flrs_trip_t trips,
	input wire logic [7:0] fuseOver,
	input wire logic [`FLRS_NSRC-1:0] srcInputs,
	input wire logic [`FLRS_NBUS-1:0] canBusFail,
	output logic [`FLRS_NBUS-1:0] canStreamRestart,
	output logic [`FLRS_NCH-1:0] channelEnable,
	output logic [`FLRS_NCH-1:0] channelClear,
	output logic warningLampOutput,
	output logic irq
);
	localparam int NCH = `FLRS_NCH;
	localparam int NBUS = `FLRS_NBUS;
	localparam int CRC = `FLRS_CANRST_CYC;

	// Bus registers
	logic [NCH-1:0] chRequest;
	logic [3:0] retryMax;
	logic [15:0] retryMs;
	logic [15:0] fuseInitMs;
	flrs_rsrc_t rsrc;
	logic [NBUS-1:0] canReport;
	logic [3:0] intStatus;
	logic [3:0] intMask;
	logic apValid;
	logic apWrite;
	logic [11:0] apAddr;

	// Channel state
	flrs_ch_t chState [NCH];
	logic [3:0] retryCnt [NCH];
	logic [47:0] chTimer [NCH]; // Wide so that ms settings times MS_CYCLES cannot wrap
	logic [NCH-1:0] chError;
	logic [NCH-1:0] chActive;
	logic [NCH-1:0] tripAny;
	logic clearPulse;

	// Reset source path
	logic srcSel;
	logic srcSync1;
	logic srcSync2;
	logic srcStable;
	logic [15:0] debCnt;
	logic srcArmed;

	// CAN supervision
	logic [NBUS-1:0] canFault;
	logic [7:0] canCnt [NBUS];

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign tripAny = trips.highCurrentTrip | trips.continuousCurrentTrip | trips.softwareFuseTrip;

	// Address phase capture; slave never inserts wait states
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			apValid <= 1'b0;
			apWrite <= 1'b0;
			apAddr <= 12'h000;
		end else if (hready) begin
			apValid <= hsel & htrans[1];
			apWrite <= hwrite;
			apAddr <= haddr[11:0];
		end
	end

	// Register writes
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			intMask <= 4'h0;
			chRequest <= '0;
			rsrc <= '0;
			canReport <= '0;
			retryMax <= `FLRS_RST_RETRYMAX;
			retryMs <= `FLRS_RST_RETRYMS;
			fuseInitMs <= `FLRS_RST_FUSEINIT;
		end else if (apValid && apWrite) begin
			case (apAddr)
				`FLRS_OFF_MASK: intMask <= hwdata[3:0];
				`FLRS_OFF_CTRL: begin
					chRequest <= hwdata[7:0];
					rsrc <= hwdata[13:8];
					canReport <= hwdata[19:16];
				end
				`FLRS_OFF_RETRYMAX: retryMax <= hwdata[3:0];
				`FLRS_OFF_RETRYMS: retryMs <= hwdata[15:0];
				`FLRS_OFF_FUSEINIT: fuseInitMs <= hwdata[15:0];
				default: ;
			endcase
		end
	end

	// Read data taken at a read address phase only, so it stands until the next read
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			hrdata <= 32'h0000_0000;
		end else if (hready && hsel && htrans[1] && !hwrite) begin
			case (haddr[11:0])
				`FLRS_OFF_STATUS: hrdata <= {28'h0, intStatus};
				`FLRS_OFF_MASK: hrdata <= {28'h0, intMask};
				`FLRS_OFF_CTRL: hrdata <= {12'h0, canReport, 2'h0, rsrc, chRequest};
				`FLRS_OFF_FAULT: hrdata <= {20'h0, canFault, chError};
				`FLRS_OFF_RETRYMAX: hrdata <= {28'h0, retryMax};
				`FLRS_OFF_RETRYMS: hrdata <= {16'h0, retryMs};
				`FLRS_OFF_FUSEINIT: hrdata <= {16'h0, fuseInitMs};
				`FLRS_OFF_ACTIVE: hrdata <= {24'h0, chActive};
				default: hrdata <= 32'h0000_0000;
			endcase
		end
	end

	// source select, lamp loops back if chosen
	assign srcSel = (rsrc.useLamp ? warningLampOutput : srcInputs[rsrc.sel]) ^ rsrc.invert;

	// Two-flop synchroniser; first stage read only by the second
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			srcSync1 <= 1'b1;
			srcSync2 <= 1'b1;
		end else begin
			srcSync1 <= srcSel;
			srcSync2 <= srcSync1;
		end
	end

	// debounce and one action per low pulse
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			srcStable <= 1'b1;
			debCnt <= 16'h0000;
			srcArmed <= 1'b1;
			clearPulse <= 1'b0;
		end else begin
			clearPulse <= 1'b0;
			if (srcSync2 == srcStable) begin
				debCnt <= 16'h0000;
			end else if (debCnt >= 16'(DEB_CYCLES - 1)) begin
				debCnt <= 16'h0000;
				srcStable <= srcSync2;
				if (!srcSync2 && srcArmed) begin
					clearPulse <= 1'b1;
					srcArmed <= 1'b0;
				end
				if (srcSync2) begin
					srcArmed <= 1'b1;
				end
			end else begin
				debCnt <= debCnt + 16'h0001;
			end
		end
	end

	// One state machine per channel
	for (genvar i = 0; i < NCH; i++) begin : g_ch
		always_ff @(posedge core_clk or negedge rst_n) begin
			if (!rst_n) begin
				chState[i] <= CH_OFF;
				retryCnt[i] <= 4'h0;
				chTimer[i] <= 48'h0;
			end else begin
				case (chState[i])
					CH_OFF: begin
						retryCnt[i] <= 4'h0;
						chTimer[i] <= 48'h0;
						if (chRequest[i]) begin
							chState[i] <= CH_ON;
						end
					end
					CH_ON: begin
						if (chTimer[i] != 48'hFFFF_FFFF_FFFF) begin
							chTimer[i] <= chTimer[i] + 48'h1;
						end
						if (!chRequest[i]) begin
							chState[i] <= CH_OFF;
						// any trip, fuse after init interval
						end else if (tripAny[i] || (fuseOver[i] &&
								chTimer[i] >= 48'(fuseInitMs) * 48'(MS_CYCLES))) begin
							chTimer[i] <= 48'h0;
							if (retryCnt[i] < retryMax) begin
								retryCnt[i] <= retryCnt[i] + 4'h1;
								chState[i] <= CH_WAIT;
							end else begin
								chState[i] <= CH_ERROR;
							end
						end
					end
					CH_WAIT: begin
						chTimer[i] <= chTimer[i] + 48'h1;
						if (chTimer[i] + 48'h1 >= 48'(retryMs) * 48'(MS_CYCLES)) begin
							chTimer[i] <= 48'h0;
							chState[i] <= CH_ON;
						end
					end
					CH_ERROR: begin
						if (clearPulse) begin
							retryCnt[i] <= 4'h0;
							chTimer[i] <= 48'h0;
							chState[i] <= chRequest[i] ? CH_ON : CH_OFF;
						end
					end
					default: chState[i] <= CH_OFF;
				endcase
			end
		end
		assign chError[i] = (chState[i] == CH_ERROR);
		assign chActive[i] = (chState[i] == CH_ON);
	end

	// Registered channel outputs
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			channelEnable <= '0;
			channelClear <= '0;
		end else begin
			channelEnable <= chActive;
			channelClear <= clearPulse ? chError : '0;
		end
	end

	// bus restart pulse held a fixed time, then retried while failure persists
	for (genvar b = 0; b < NBUS; b++) begin : g_can
		always_ff @(posedge core_clk or negedge rst_n) begin
			if (!rst_n) begin
				canCnt[b] <= 8'h00;
				canStreamRestart[b] <= 1'b0;
			end else if (canCnt[b] != 8'h00) begin
				canCnt[b] <= canCnt[b] - 8'h01;
				canStreamRestart[b] <= (canCnt[b] != 8'h01);
			end else if (canBusFail[b]) begin
				canCnt[b] <= 8'(CRC);
				canStreamRestart[b] <= 1'b1;
			end else begin
				canStreamRestart[b] <= 1'b0;
			end
		end
	end

	// only enabled buses count as faults for the lamp and FAULT register; the status event bit sets on any bus
	assign canFault = canBusFail & canReport;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			warningLampOutput <= 1'b0;
		end else begin
			warningLampOutput <= (|chError) | (|canFault);
		end
	end

	// Sticky events; set wins over write-one-to-clear
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			intStatus <= 4'h0;
		end else begin
			intStatus <= (intStatus & ~((apValid && apWrite && apAddr == `FLRS_OFF_STATUS)
				? hwdata[3:0] : 4'h0))
				| {|canBusFail, clearPulse, |tripAny, |chError};
		end
	end

	assign irq = |(intStatus & intMask);
endmodule : flrs_fault_supervisor
`default_nettype wire

// ### flrs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module flrs_monitor
	import flrs_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire flrs_trip_t trips,
	input wire logic [3:0] canBusFail,
	input wire logic [3:0] canStreamRestart,
	input wire logic [7:0] channelEnable,
	input wire logic [7:0] channelClear,
	input wire logic warningLampOutput
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// Failure onset of the watched bus
	sequence canFailStart;
		$rose(canBusFail[0]);
	endsequence
	// Clear pulse seen on any channel
	sequence clearSeen;
		channelClear != 8'h00;
	endsequence
	bus_okay_a: assert property (hreadyout && !hresp)
		else $error("bus answer not ready and okay");
	read_hold_a: assert property ($changed(hrdata) |-> $past(hsel && htrans[1] && hready))
		else $error("read data moved without an address phase");
	clear_once_a: assert property (clearSeen |=> channelClear == 8'h00)
		else $error("clear pulse longer than one cycle");
	clear_lamp_a: assert property (clearSeen |-> $past(warningLampOutput))
		else $error("clear without lamp lit");
	clear_idle_a: assert property (clearSeen |-> (channelClear & $past(channelEnable, 2)) == 8'h00)
		else $error("clear hit a running channel");
	trip_off_a: assert property (trips.highCurrentTrip[0] && channelEnable[0] |-> ##[1:3] !channelEnable[0])
		else $error("tripped channel stayed on");
	can_restart_a: assert property (canFailStart |-> ##[1:3] canStreamRestart[0])
		else $error("no stream restart after bus failure");
	restart_len_a: assert property ($rose(canStreamRestart[0]) |=> canStreamRestart[0] [*8])
		else $error("stream restart too short");
endmodule : flrs_monitor
bind flrs_fault_supervisor flrs_monitor flrs_monitor_i (.core_clk, .rst_n, .hsel, .htrans, .hready,
	.hrdata, .hreadyout, .hresp, .trips, .canBusFail, .canStreamRestart, .channelEnable,
	.channelClear, .warningLampOutput);
`default_nettype wire

// ### flrs_load_model.sv
`timescale 1ns/1ps
`default_nettype none
module flrs_load_model
	import flrs_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire flrs_trip_t overload,
	input wire logic groundReset,
	output flrs_trip_t trips,
	output logic [15:0] srcInputs
);
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) trips <= '0;
		else trips <= overload;
	end
	assign srcInputs = {15'h7FFF, !groundReset};
endmodule : flrs_load_model
`default_nettype wire

// ### fault_lamp_and_reset_supervisor_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "flrs_params.svh"
module fault_lamp_and_reset_supervisor_tb
	import flrs_pkg::*;
;
	logic core_clk, rst_n, hsel, hwrite, hready, hreadyout, hresp, warningLampOutput, irq;
	logic groundReset;
	logic [31:0] haddr, hwdata, hrdata, r;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [7:0] fuseOver, channelEnable, channelClear;
	logic [15:0] srcInputs;
	logic [3:0] canBusFail, canStreamRestart;
	flrs_trip_t trips, overload;
	int num_errors, checks, cycles, k, n;
	// Address and expected reset value
	logic [31:0] rows [5][2] = '{'{32'(`FLRS_OFF_RETRYMAX), 32'(`FLRS_RST_RETRYMAX)},
		'{32'(`FLRS_OFF_RETRYMS), 32'(`FLRS_RST_RETRYMS)},
		'{32'(`FLRS_OFF_FUSEINIT), 32'(`FLRS_RST_FUSEINIT)},
		'{32'(`FLRS_OFF_FAULT), 32'h0}, '{32'h30, 32'h0}};
	// Short millisecond so timed paths fit the run
	localparam int MS_SIM = 10;
	assign hready = hreadyout;
	flrs_fault_supervisor #(.MS_CYCLES(MS_SIM), .DEB_CYCLES(4)) flrs_fault_supervisor_i (.core_clk,
		.rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout,
		.hresp, .trips, .fuseOver, .srcInputs, .canBusFail, .canStreamRestart, .channelEnable,
		.channelClear, .warningLampOutput, .irq);
	flrs_load_model flrs_load_model_i (.core_clk, .rst_n, .overload, .groundReset, .trips,
		.srcInputs);
	// Clock
	initial begin
		core_clk = 0;
		forever #4 core_clk = ~core_clk;
	end
	// Hang guard
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			summarize();
		end
	end
	task automatic summarize();
		if (num_errors == 0 && checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : summarize
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			$display("unexpected %s expected %h seen %h", name, exp, got);
			num_errors++;
		end
	endtask : chk
	// Single word transfer, waits on ready each phase
	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		hsel <= 0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask : ahb
	initial begin
		rst_n = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hsize = 3'h2; hwdata = 0;
		overload = '0; groundReset = 0; canBusFail = 0; fuseOver = 0;
		repeat (4) @(posedge core_clk);
		rst_n <= 1;
		@(posedge core_clk);
		chk("lamp", 0, warningLampOutput);
		for (k = 0; k < 5; k++) begin
			ahb(0, rows[k][0], 0);
			chk("reset value", rows[k][1], r);
		end
		ahb(1, `FLRS_OFF_RETRYMAX, 0);
		ahb(1, `FLRS_OFF_MASK, 1);
		ahb(1, `FLRS_OFF_CTRL, 32'h000100FF);
		repeat (3) @(posedge core_clk);
		chk("enable", 8'hFF, channelEnable);
		overload <= '{8'h01, 8'h02, 8'h04};
		for (k = 0; k < 20 && channelEnable !== 8'hF8; k++) @(posedge core_clk);
		overload <= '0;
		repeat (3) @(posedge core_clk);
		chk("enable", 8'hF8, channelEnable);
		chk("lamp", 1, warningLampOutput);
		chk("irq", 1, irq);
		ahb(1, `FLRS_OFF_MASK, 0);
		@(posedge core_clk);
		chk("irq", 0, irq);
		groundReset <= 1;
		n = 0;
		repeat (40) begin
			@(posedge core_clk);
			n += (channelClear === 8'h07);
		end
		groundReset <= 0;
		chk("clears", 1, n);
		repeat (10) @(posedge core_clk);
		chk("lamp", 0, warningLampOutput);
		ahb(1, `FLRS_OFF_STATUS, 32'hF);
		ahb(1, `FLRS_OFF_MASK, 1);
		@(posedge core_clk);
		chk("irq", 0, irq);
		ahb(1, `FLRS_OFF_RETRYMAX, 1);
		ahb(1, `FLRS_OFF_RETRYMS, 1);
		repeat (30) @(posedge core_clk);
		overload <= '{8'h08, 8'h00, 8'h00};
		@(posedge core_clk);
		overload <= '0;
		for (k = 0; k < 10 && channelEnable[3] !== 1'b0; k++) @(posedge core_clk);
		for (k = 0; k < 40 && channelEnable[3] !== 1'b1; k++) @(posedge core_clk);
		chk("retry", 1, channelEnable[3]);
		chk("lamp", 0, warningLampOutput);
		canBusFail <= 4'h2;
		repeat (5) @(posedge core_clk);
		chk("lamp", 0, warningLampOutput);
		canBusFail <= 4'h3;
		repeat (5) @(posedge core_clk);
		chk("lamp", 1, warningLampOutput);
		chk("restart", 1, canStreamRestart[0]);
		canBusFail <= 0;
		// Fuse overrun: first trip, one retry, then shut off only after the init interval
		ahb(1, `FLRS_OFF_FUSEINIT, 1);
		fuseOver <= 8'h10;
		for (k = 0; k < 10 && channelEnable[4] !== 1'b0; k++) @(posedge core_clk);
		for (k = 0; k < 40 && channelEnable[4] !== 1'b1; k++) @(posedge core_clk);
		for (n = 0; n < 40 && channelEnable[4] !== 1'b0; n++) @(posedge core_clk);
		chk("fuse delay", 1, 32'(n >= MS_SIM && n <= MS_SIM + 2));
		@(posedge core_clk);
		chk("lamp", 1, warningLampOutput);
		// Lamp as inverted reset source: a lit lamp clears the errored channel once
		fuseOver <= 8'h00;
		ahb(1, `FLRS_OFF_CTRL, 32'h000103FF);
		n = 0;
		repeat (30) begin
			@(posedge core_clk);
			n += (channelClear === 8'h10);
		end
		chk("lamp clears", 1, n);
		chk("lamp", 0, warningLampOutput);
		// Mid-run reset: outputs drop and registers reload
		rst_n <= 0;
		repeat (2) @(posedge core_clk);
		chk("enable", 0, channelEnable);
		rst_n <= 1;
		@(posedge core_clk);
		ahb(0, 32'(`FLRS_OFF_RETRYMAX), 0);
		chk("reset value", 32'(`FLRS_RST_RETRYMAX), r);
		summarize();
	end
endmodule : fault_lamp_and_reset_supervisor_tb
`default_nettype wire
